// ---- hw/wdt_feed_timer.sv ----
// The register offsets and the APB register port were left to the implementer.
module wdt_feed_timer
    import wdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wdt_reset_pulse,
    output logic timeout_flag
);
    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // one address comparison shared by every register decode
    function automatic logic wdt_hit(
        input logic [11:0] addr,
        input logic [11:0] reg_addr
    );
        return addr == reg_addr;
    endfunction

    // one key comparison shared by both halves of the feed
    function automatic logic wdt_key(
        input logic [7:0] value,
        input logic [7:0] key
    );
        return value == key;
    endfunction

    // byte registers read back in the low lane with the upper lanes zero
    function automatic logic [31:0] wdt_word(
        input logic [7:0] value
    );
        return 32'(value);
    endfunction

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire hit_ctrl = wdt_hit(paddr, WDT_ADDR_CTRL);
    wire hit_auto = wdt_hit(paddr, WDT_ADDR_AUTOLOAD);
    wire hit_feed1 = wdt_hit(paddr, WDT_ADDR_FEED1);
    wire hit_feed2 = wdt_hit(paddr, WDT_ADDR_FEED2);
    wire hit_count = wdt_hit(paddr, WDT_ADDR_COUNT);
    wire mapped = hit_ctrl || hit_auto || hit_feed1 || hit_feed2 || hit_count;
    wire [7:0] wbyte = pwdata[7:0];

    // ------------------------------------------------------------
    // write strobes and control fields
    // ------------------------------------------------------------
    wire ctrl_wr = wr && hit_ctrl;
    wire auto_wr = wr && hit_auto;
    wire feed1_wr = wr && hit_feed1;
    wire feed2_wr = wr && hit_feed2;
    wire [2:0] tap_field = wbyte[WDT_TAP_HI:WDT_TAP_LO];
    wire run_field = wbyte[WDT_RUN_BIT];
    wire tof_field = wbyte[WDT_TOF_BIT];
    // writing zero to the flag clears it, writing one leaves it alone
    wire tof_clear = ctrl_wr && !tof_field;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    typedef enum logic {
        WDT_FEED_IDLE,
        WDT_FEED_ARMED
    } wdt_feed_e;

    wdt_feed_e feed_state_reg;
    wdt_feed_e feed_state_next;
    logic [2:0] tap_reg;
    logic run_reg;
    logic [2:0] tap_pend_reg;
    logic run_pend_reg;
    logic timeout_flag_reg;
    logic [7:0] autoload_value_reg;
    logic wdt_reset_reg;
    logic [7:0] count;
    logic underflow;

    // ------------------------------------------------------------
    // feed sequence
    // ------------------------------------------------------------
    wire armed = feed_state_reg == WDT_FEED_ARMED;
    wire key1_ok = feed1_wr && wdt_key(wbyte, WDT_KEY_FIRST);
    wire key2_ok = wdt_key(wbyte, WDT_KEY_SECOND);
    wire feed_ok = armed && feed2_wr && key2_ok;
    wire feed_bad_key = armed && feed2_wr && !key2_ok;
    // any other completed access while armed, a read of the second key too, breaks the feed
    wire feed_broken = armed && access && !feed2_wr;
    wire feed_fail = feed_bad_key || feed_broken;
    // software has no other way to load the counter
    wire load = feed_ok;
    wire wdt_reset_next = feed_fail || underflow;

    always_comb begin
        feed_state_next = feed_state_reg;
        unique case (feed_state_reg)
            WDT_FEED_IDLE: begin
                // a wrong first key simply leaves the sequence unarmed
                if (key1_ok) begin
                    feed_state_next = WDT_FEED_ARMED;
                end
            end
            WDT_FEED_ARMED: begin
                // the very next completed access closes the sequence, good or bad
                if (access) begin
                    feed_state_next = WDT_FEED_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feed_state_reg <= WDT_FEED_IDLE;
        end else begin
            feed_state_reg <= feed_state_next;
        end
    end

    // ------------------------------------------------------------
    // control and autoload
    // ------------------------------------------------------------
    // control writes of tap and run wait here until the next valid feed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_pend_reg <= WDT_TAP_RESET;
            run_pend_reg <= WDT_RUN_RESET;
        end else if (ctrl_wr) begin
            tap_pend_reg <= tap_field;
            run_pend_reg <= run_field;
        end
    end

    // only a valid feed moves the pending settings onto the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tap_reg <= WDT_TAP_RESET;
            run_reg <= WDT_RUN_RESET;
        end else if (feed_ok) begin
            tap_reg <= tap_pend_reg;
            run_reg <= run_pend_reg;
        end
    end

    // untouched by underflow, so the value survives a watchdog reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            autoload_value_reg <= WDT_AUTOLOAD_RESET;
        end else if (auto_wr) begin
            autoload_value_reg <= wbyte;
        end
    end

    // ------------------------------------------------------------
    // timeout flag and system reset request
    // ------------------------------------------------------------
    // underflow wins over a software clear in the same cycle, so no timeout is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_reg <= 1'b0;
        end else if (underflow) begin
            timeout_flag_reg <= 1'b1;
        end else if (tof_clear) begin
            timeout_flag_reg <= 1'b0;
        end
    end

    // registered so that the request is a clean one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_reg <= 1'b0;
        end else begin
            wdt_reset_reg <= wdt_reset_next;
        end
    end

    assign wdt_reset_pulse = wdt_reset_reg;
    assign timeout_flag = timeout_flag_reg;

    // ------------------------------------------------------------
    // counter core
    // ------------------------------------------------------------
    wdt_timer_core u_core (
        .pclk(pclk),
        .presetn(presetn),
        .run(run_reg),
        .tap_sel(tap_reg),
        .autoload_value(autoload_value_reg),
        .load(load),
        .count(count),
        .underflow(underflow)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // tap reads back the pending value, run the value in force
    wire [7:0] ctrl_view = {tap_pend_reg, 2'b00, run_reg, timeout_flag_reg, 1'b0};
    wire [31:0] rd_ctrl = wdt_word(ctrl_view);
    wire [31:0] rd_auto = wdt_word(autoload_value_reg);
    wire [31:0] rd_count = wdt_word(count);
    wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                         hit_auto ? rd_auto :
                         hit_count ? rd_count : WDT_RDATA_ZERO;

    // captured in the setup cycle so read data stands through the whole access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= WDT_RDATA_ZERO;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // bus response
    // ------------------------------------------------------------
    // every register answers at once, so the bus never waits
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
endmodule

// ---- hw/wdt_timer_core.sv ----
module wdt_timer_core
    import wdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic [2:0] tap_sel,
    input wire logic [WDT_CNT_W-1:0] autoload_value,
    input wire logic load,
    output logic [WDT_CNT_W-1:0] count,
    output logic underflow
);
    // ------------------------------------------------------------
    // prescaler and main down-counter
    // ------------------------------------------------------------
    logic [WDT_PRE_W-1:0] pre_reg;
    logic [WDT_PRE_W-1:0] pre_next;
    logic [WDT_CNT_W-1:0] cnt_reg;
    logic tap_old_reg;
    wire [3:0] tap_index = {1'b0, tap_sel} + 4'(WDT_TAP_BASE);
    wire tap_now = pre_next[tap_index];
    // falling edge of the tap bit: one pulse per 2^(tap_index+1) clocks
    wire dec_pulse = run && tap_old_reg && !tap_now;
    assign pre_next = pre_reg + WDT_PRE_ONE;
    assign underflow = dec_pulse && (cnt_reg == WDT_CNT_ZERO) && !load;
    assign count = cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= WDT_PRE_ZERO;
            cnt_reg <= WDT_AUTOLOAD_RESET;
            tap_old_reg <= 1'b0;
        end else if (load || underflow) begin
            // clearing the prescaler on autoload gives a full tap period even at zero
            pre_reg <= WDT_PRE_ZERO;
            cnt_reg <= autoload_value;
            tap_old_reg <= 1'b0;
        end else if (run) begin
            pre_reg <= pre_next;
            tap_old_reg <= tap_now;
            if (dec_pulse) begin
                cnt_reg <= cnt_reg - WDT_CNT_ONE;
            end
        end
    end
endmodule

// ---- inc/wdt_pkg.sv ----
package wdt_pkg;
    // register byte addresses on the apb bus
    localparam logic [11:0] WDT_ADDR_CTRL = 12'h000;
    localparam logic [11:0] WDT_ADDR_AUTOLOAD = 12'h004;
    localparam logic [11:0] WDT_ADDR_FEED1 = 12'h008;
    localparam logic [11:0] WDT_ADDR_FEED2 = 12'h00C;
    localparam logic [11:0] WDT_ADDR_COUNT = 12'h010;
    // control register fields
    localparam int WDT_TAP_HI = 7;
    localparam int WDT_TAP_LO = 5;
    localparam int WDT_RUN_BIT = 2;
    localparam int WDT_TOF_BIT = 1;
    localparam logic [2:0] WDT_TAP_RESET = 3'h7;
    localparam logic WDT_RUN_RESET = 1'b1;
    localparam logic [7:0] WDT_AUTOLOAD_RESET = 8'h00;
    // feed keys
    localparam logic [7:0] WDT_KEY_FIRST = 8'hA5;
    localparam logic [7:0] WDT_KEY_SECOND = 8'h5A;
    // counter geometry
    localparam int WDT_PRE_W = 13;
    localparam int WDT_CNT_W = 8;
    localparam int WDT_TAP_BASE = 4;
    localparam logic [WDT_PRE_W-1:0] WDT_PRE_ZERO = 13'h0000;
    localparam logic [WDT_PRE_W-1:0] WDT_PRE_ONE = 13'h0001;
    localparam logic [WDT_CNT_W-1:0] WDT_CNT_ZERO = 8'h00;
    localparam logic [WDT_CNT_W-1:0] WDT_CNT_ONE = 8'h01;
    localparam logic [31:0] WDT_RDATA_ZERO = 32'h0000_0000;
endpackage

// ---- verification/tb_top.sv ----
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_top
    import wdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic wdt_reset_pulse, timeout_flag, seen, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int error_cnt = 0, checked = 0;
    wdt_feed_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdt_reset_pulse(wdt_reset_pulse), .timeout_flag(timeout_flag));
    initial begin
        forever #50 pclk = ~pclk;
    end
    // ----
    // bus and helper tasks
    // ----
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic feed();
        apb(1'b1, WDT_ADDR_FEED1, 32'h0000_00A5);
        apb(1'b1, WDT_ADDR_FEED2, 32'h0000_005A);
    endtask
    task automatic pulse_in(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(posedge pclk);
            if (wdt_reset_pulse === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        pulse_in(4000);
        `CHK(seen, 1'b0)
        pulse_in(200);
        `CHK(seen, 1'b1)
        `CHK(timeout_flag, 1'b1)
        apb(1'b0, WDT_ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0000_00E6)
        apb(1'b0, WDT_ADDR_AUTOLOAD, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, WDT_ADDR_CTRL, 32'h0000_0004);
        apb(1'b0, WDT_ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h0000_0004)
        for (int w = 0; w < 6; w += 3) begin
            apb(1'b1, WDT_ADDR_AUTOLOAD, 32'(w));
            feed();
            apb(1'b0, WDT_ADDR_COUNT, 32'h0);
            `CHK(rd, 32'(w))
            pulse_in((w + 1) * 32 - 16);
            `CHK(seen, 1'b0)
            pulse_in(24);
            `CHK(seen, 1'b1)
        end
        apb(1'b1, WDT_ADDR_AUTOLOAD, 32'h0000_00FF);
        feed();
        apb(1'b1, WDT_ADDR_FEED1, 32'h0000_0012);
        apb(1'b1, WDT_ADDR_FEED2, 32'h0000_005A);
        pulse_in(4);
        `CHK(seen, 1'b0)
        apb(1'b1, WDT_ADDR_FEED1, 32'h0000_00A5);
        apb(1'b0, WDT_ADDR_AUTOLOAD, 32'h0);
        pulse_in(3);
        `CHK(seen, 1'b1)
        apb(1'b1, WDT_ADDR_FEED1, 32'h0000_00A5);
        apb(1'b0, WDT_ADDR_FEED2, 32'h0);
        pulse_in(3);
        `CHK(seen, 1'b1)
        apb(1'b1, WDT_ADDR_FEED1, 32'h0000_00A5);
        apb(1'b1, WDT_ADDR_FEED2, 32'h0000_0033);
        pulse_in(3);
        `CHK(seen, 1'b1)
        apb(1'b1, WDT_ADDR_AUTOLOAD, 32'h0);
        apb(1'b1, WDT_ADDR_CTRL, 32'h0);
        feed();
        apb(1'b0, WDT_ADDR_COUNT, 32'h0);
        `CHK(rd, 32'h0000_0000)
        pulse_in(300);
        `CHK(seen, 1'b0)
        apb(1'b1, WDT_ADDR_COUNT, 32'h0000_0055);
        apb(1'b0, WDT_ADDR_COUNT, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(err, 1'b0)
        apb(1'b0, 12'h020, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        give_verdict();
    end
    initial begin
        #3000000;
        error_cnt++;
        give_verdict();
    end
endmodule
bind wdt_feed_timer wdt_feed_timer_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_reset_pulse(wdt_reset_pulse),
    .timeout_flag(timeout_flag));

// ---- verification/wdt_feed_timer_properties.sv ----
module wdt_feed_timer_properties
    import wdt_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wdt_reset_pulse,
    input wire logic timeout_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic armed_reg;
    wire logic acc = psel && penable && pready;
    wire logic to_f2 = acc && pwrite && paddr == WDT_ADDR_FEED2;
    wire logic f1_ok = acc && pwrite && paddr == WDT_ADDR_FEED1 && pwdata[7:0] == WDT_KEY_FIRST;
    wire logic mapped = paddr <= WDT_ADDR_COUNT && paddr[1:0] == 2'h0;
    // a reset pulse may drop a half-done feed, so tracking stops there
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_reg <= 1'b0;
        end else if (acc || wdt_reset_pulse) begin
            armed_reg <= !armed_reg && f1_ok;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_pulse_single: assert property (wdt_reset_pulse |=> !wdt_reset_pulse) else $error("long pulse");
    a_slverr_hole: assert property (psel && penable && !mapped |-> pslverr) else $error("no slverr");
    a_slverr_map: assert property (psel && penable && mapped |-> !pslverr) else $error("bad slverr");
    a_bad_second: assert property (to_f2 && armed_reg && pwdata[7:0] != WDT_KEY_SECOND
        |=> wdt_reset_pulse) else $error("bad key kept");
    a_feed_broken: assert property (armed_reg && acc && !to_f2 |=> wdt_reset_pulse)
        else $error("intervening access kept");
    a_flag_clear: assert property (acc && pwrite && paddr == WDT_ADDR_CTRL
        && !pwdata[WDT_TOF_BIT] |=> !timeout_flag || wdt_reset_pulse) else $error("flag kept");
    a_read_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits");
    a_flag_pulse: assert property ($rose(timeout_flag) |-> ##[0:1] wdt_reset_pulse)
        else $error("flag without reset");
    c_feed_ok: cover property (armed_reg && to_f2 && pwdata[7:0] == WDT_KEY_SECOND);
    c_pulse: cover property (wdt_reset_pulse);
    c_slverr: cover property (pslverr);
endmodule
